// ---- hw/rx_signal_loss_status_irq.sv ----
// Signal-loss status, thresholds and interrupt for receivers 0 to 5.
// Assumes an APB master on pclk and inputs synchronous to pclk.
//
// Behaviour
// R01 - Index 0x8C bits [5:0] read the live loss state, 1 meaning no signal.
// R02 - Index 0x8D bits [5:0] read 1 once a loss event has occurred on that receiver.
// R03 - Both status registers reset to zero, bit 7 is spare storage, bits [5:0] are not writable except that a written one clears a latched bit.
// R04 - Live loss clears when the amplitude rises above the upper nibble of index 0x8E.
// R05 - Live loss sets when the amplitude falls below the lower nibble of index 0x8E.
// R06 - Threshold code n means n times 25 mV peak-to-peak, codes 0x0 to 0xC spanning 300 mV.
// R07 - Software keeps the release code above the trip code.
// R08 - The level register resets to 0x62, release 6 and trip 2.
// R09 - Index 0x8F bits [5:0] let each receiver's event reach the interrupt, all 0 at reset.
// R10 - The interrupt is the OR of enabled events of this group and of receivers 6 to 11.
// R11 - Mask bits [7:6] are spare storage that reset to zero.
// R12 - A detector works only while its enable bit at index 0x88 is 1.
// R13 - A 4-bit time code per receiver sets the squelch delay, code 0 is 2.5 ns, reset 0x9.
// R14 - A latched event bit holds until reset or an explicit clear by software.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module rx_signal_loss_status_irq #(
	parameter int RX_COUNT = rx_loss_pkg::RX_COUNT,
	parameter int CODE_W   = rx_loss_pkg::CODE_W
) (
	input  wire logic                              pclk,
	input  wire logic                              presetn,
	input  wire logic                              psel,
	input  wire logic                              penable,
	input  wire logic                              pwrite,
	input  wire logic [rx_loss_pkg::ADDR_W-1:0]    paddr,
	input  wire logic [rx_loss_pkg::APB_DW-1:0]    pwdata,
	output logic      [rx_loss_pkg::APB_DW-1:0]    prdata,
	output logic                                   pready,
	output logic                                   pslverr,
	input  wire logic [RX_COUNT-1:0][CODE_W-1:0]   rx_amplitude,
	input  wire logic                              upper_group_irq,
	output logic      [RX_COUNT-1:0]               rx_squelch,
	output logic                                   loss_ref_enable,
	output logic                                   loss_irq
);

	localparam int RW = rx_loss_pkg::REG_W;

	// ------------------------------------------------------------------
	// Address decode.
	// ------------------------------------------------------------------

	logic [rx_loss_pkg::IDX_W-1:0] idx;
	logic                          word_ok;
	logic                          hit_enable;
	logic                          hit_time10;
	logic                          hit_time32;
	logic                          hit_time54;
	logic                          hit_live;
	logic                          hit_latched;
	logic                          hit_levels;
	logic                          hit_mask;
	logic                          mapped;
	logic                          setup_phase;
	logic                          access_phase;
	logic                          wr_en;

	assign idx     = paddr[rx_loss_pkg::ADDR_W-1:2];
	assign word_ok = (paddr[1:0] == 2'b00);

	assign hit_enable  = word_ok && (idx == rx_loss_pkg::IDX_LOSS_ENABLE);
	assign hit_time10  = word_ok && (idx == rx_loss_pkg::IDX_TIME_10);
	assign hit_time32  = word_ok && (idx == rx_loss_pkg::IDX_TIME_32);
	assign hit_time54  = word_ok && (idx == rx_loss_pkg::IDX_TIME_54);
	assign hit_live    = word_ok && (idx == rx_loss_pkg::IDX_LIVE);
	assign hit_latched = word_ok && (idx == rx_loss_pkg::IDX_LATCHED);
	assign hit_levels  = word_ok && (idx == rx_loss_pkg::IDX_LEVELS);
	assign hit_mask    = word_ok && (idx == rx_loss_pkg::IDX_MASK);

	assign mapped = hit_enable | hit_time10 | hit_time32 | hit_time54 |
		hit_live | hit_latched | hit_levels | hit_mask;

	assign setup_phase  = psel & ~penable;
	assign access_phase = psel & penable;

	// The slave never inserts wait states: every access phase completes.
	assign pready  = 1'b1;
	assign pslverr = access_phase & ~mapped;
	assign wr_en   = access_phase & pwrite & mapped;

	// ------------------------------------------------------------------
	// Registers.
	// ------------------------------------------------------------------

	logic [RW-1:0]       enable_reg;
	logic [RW-1:0]       time10_reg;
	logic [RW-1:0]       time32_reg;
	logic [RW-1:0]       time54_reg;
	logic [RW-1:0]       levels_reg;
	logic [RW-1:0]       mask_reg;
	logic                spare_live_reg;
	logic                spare_latched_reg;
	logic [RX_COUNT-1:0] latched_reg;
	logic [RX_COUNT-1:0] latched_next;
	logic [RX_COUNT-1:0] latched_clear;
	// Nets, because each generate branch drives its own bit.
	wire logic [RX_COUNT-1:0] live_loss_bits;
	wire logic [RX_COUNT-1:0] loss_events;
	wire logic [RX_COUNT-1:0] squelch_bits;
	logic [RW-1:0]       wbyte;

	assign wbyte = pwdata[RW-1:0];

	// Writing a one clears a latched bit; a new event in the same cycle wins.
	assign latched_clear = (wr_en && hit_latched) ? wbyte[RX_COUNT-1:0] : '0;
	assign latched_next  = (latched_reg & ~latched_clear) | loss_events;     // R14

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_reg <= rx_loss_pkg::RST_LOSS_ENABLE;
			time10_reg <= rx_loss_pkg::RST_TIME;                         // R13
			time32_reg <= rx_loss_pkg::RST_TIME;                         // R13
			time54_reg <= rx_loss_pkg::RST_TIME;                         // R13
			levels_reg <= rx_loss_pkg::RST_LEVELS;                       // R08
			mask_reg   <= rx_loss_pkg::RST_MASK;                         // R09 R11
		end else if (wr_en) begin
			if (hit_enable) begin
				enable_reg <= wbyte;
			end
			if (hit_time10) begin
				time10_reg <= wbyte;
			end
			if (hit_time32) begin
				time32_reg <= wbyte;
			end
			if (hit_time54) begin
				time54_reg <= wbyte;
			end
			if (hit_levels) begin
				levels_reg <= wbyte;                                     // R04 R05
			end
			if (hit_mask) begin
				mask_reg <= wbyte;                                       // R09 R11
			end
		end
	end

	// Only bit 7 of each status register stores a write; bits [5:0] are status.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			spare_live_reg    <= rx_loss_pkg::RST_STATUS[rx_loss_pkg::SPARE_STATUS_BIT];
			spare_latched_reg <= rx_loss_pkg::RST_STATUS[rx_loss_pkg::SPARE_STATUS_BIT];
		end else if (wr_en) begin
			if (hit_live) begin
				spare_live_reg <= wbyte[rx_loss_pkg::SPARE_STATUS_BIT];      // R03
			end
			if (hit_latched) begin
				spare_latched_reg <= wbyte[rx_loss_pkg::SPARE_STATUS_BIT];   // R03
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latched_reg <= '0;                                               // R03
		end else begin
			latched_reg <= latched_next;                                     // R02
		end
	end

	// ------------------------------------------------------------------
	// Per-receiver detectors.
	// ------------------------------------------------------------------

	logic [3*RW-1:0] time_codes;

	assign time_codes = {time54_reg, time32_reg, time10_reg};

	genvar g;
	generate
		for (g = 0; g < RX_COUNT; g++) begin : g_rx
			wire rx_loss_pkg::det_cfg_type cfg;
			rx_loss_pkg::det_stat_type stat;

			// Codes above 0xC are passed through; the analog range ends at 300 mV.
			assign cfg.enable            = enable_reg[g];                    // R12
			assign cfg.release_threshold =
				levels_reg[rx_loss_pkg::RELEASE_LSB +: CODE_W];                // R04 R06
			assign cfg.trip_threshold    =
				levels_reg[rx_loss_pkg::TRIP_LSB +: CODE_W];                   // R05 R06
			assign cfg.time_code         = time_codes[g*CODE_W +: CODE_W];   // R13

			rx_loss_detector u_det (
				.pclk      (pclk),
				.presetn   (presetn),
				.cfg       (cfg),
				.amplitude (rx_amplitude[g]),
				.stat      (stat)
			);

			assign live_loss_bits[g] = stat.live_loss;                       // R01
			assign loss_events[g]    = stat.loss_event;                      // R02
			assign squelch_bits[g]   = stat.squelch;
		end
	endgenerate

	assign rx_squelch = squelch_bits;

	// The hysteresis relies on software keeping release above trip; a
	// reversed pair lets the trip compare win wherever both compares hold.
	// R07

	assign loss_ref_enable = enable_reg[rx_loss_pkg::REF_ENABLE_BIT];

	// ------------------------------------------------------------------
	// Interrupt.
	// ------------------------------------------------------------------

	logic irq_reg;

	// Registered so the pin never glitches on a decode edge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(latched_next & mask_reg[RX_COUNT-1:0]) | upper_group_irq; // R09 R10
		end
	end

	assign loss_irq = irq_reg;

	// ------------------------------------------------------------------
	// Read path.
	// ------------------------------------------------------------------

	logic [RW-1:0]                   live_view;
	logic [RW-1:0]                   latched_view;
	logic [RW-1:0]                   read_byte;
	logic [rx_loss_pkg::APB_DW-1:0]  prdata_reg;

	// Bit 6 of both status registers is unused and reads zero.
	assign live_view    = {spare_live_reg, {(RW-1-RX_COUNT){1'b0}}, live_loss_bits};  // R01 R03
	assign latched_view = {spare_latched_reg, {(RW-1-RX_COUNT){1'b0}}, latched_reg}; // R02 R03

	assign read_byte =
		hit_enable  ? enable_reg   :
		hit_time10  ? time10_reg   :
		hit_time32  ? time32_reg   :
		hit_time54  ? time54_reg   :
		hit_live    ? live_view    :
		hit_latched ? latched_view :
		hit_levels  ? levels_reg   :
		hit_mask    ? mask_reg     :
		8'h00;

	// Read data is sampled in the setup cycle so it leaves a flip-flop
	// during the access cycle; live bits are one cycle old when read.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
		end else if (setup_phase && !pwrite) begin
			prdata_reg <= {{(rx_loss_pkg::APB_DW-RW){1'b0}}, read_byte};
		end
	end

	assign prdata = prdata_reg;

endmodule
`default_nettype wire

// ---- hw/rx_loss_pkg.sv ----
// Package for the receiver signal-loss status and interrupt block.
// Assumes a 40 MHz APB clock and six receivers in this group.
package rx_loss_pkg;

	localparam int RX_COUNT = 6;
	localparam int CODE_W   = 4;
	localparam int REG_W    = 8;
	localparam int APB_DW   = 32;
	localparam int ADDR_W   = 10;
	localparam int IDX_W    = ADDR_W - 2;

	// Register indices; the byte address is four times the index.
	localparam logic [IDX_W-1:0] IDX_LOSS_ENABLE = 8'h88;
	localparam logic [IDX_W-1:0] IDX_TIME_10     = 8'h89;
	localparam logic [IDX_W-1:0] IDX_TIME_32     = 8'h8A;
	localparam logic [IDX_W-1:0] IDX_TIME_54     = 8'h8B;
	localparam logic [IDX_W-1:0] IDX_LIVE        = 8'h8C;
	localparam logic [IDX_W-1:0] IDX_LATCHED     = 8'h8D;
	localparam logic [IDX_W-1:0] IDX_LEVELS      = 8'h8E;
	localparam logic [IDX_W-1:0] IDX_MASK        = 8'h8F;

	localparam logic [REG_W-1:0] RST_LOSS_ENABLE = 8'h40;
	localparam logic [REG_W-1:0] RST_TIME        = 8'h99;
	localparam logic [REG_W-1:0] RST_STATUS      = 8'h00;
	localparam logic [REG_W-1:0] RST_LEVELS      = 8'h62;
	localparam logic [REG_W-1:0] RST_MASK        = 8'h00;

	localparam int SPARE_STATUS_BIT = 7;
	localparam int REF_ENABLE_BIT   = 6;
	localparam int SPARE_ENABLE_BIT = 7;
	localparam int SPARE_MASK_LSB   = 6;
	localparam int RELEASE_LSB      = 4;
	localparam int TRIP_LSB         = 0;

	// Squelch delays per time code, in nanoseconds as printed.
	localparam real CLK_PERIOD_NS = 25.0;
	localparam real SQ_TIME_NS [16] = '{
		2.5, 5.0, 10.0, 20.0, 40.0, 80.0, 160.0, 320.0,
		460.0, 1280.0, 2560.0, 5120.0, 10240.0, 20480.0, 40960.0, 81920.0
	};

	localparam int SQ_CNT_W = 12;
	typedef logic [SQ_CNT_W-1:0] sq_table_type [16];

	// Least times round up to whole cycles, never below one.
	function automatic sq_table_type build_sq_table();
		sq_table_type t;
		int           c;
		for (int i = 0; i < 16; i++) begin
			c = int'($ceil(SQ_TIME_NS[i] / CLK_PERIOD_NS));
			if (c < 1) begin
				c = 1;
			end
			t[i] = SQ_CNT_W'(c);
		end
		return t;
	endfunction

	localparam sq_table_type SQ_CYCLES = build_sq_table();

	function automatic logic [IDX_W+1:0] byte_addr(input logic [IDX_W-1:0] idx);
		return {idx, 2'b00};
	endfunction

	typedef struct packed {
		logic              enable;
		logic [CODE_W-1:0] release_threshold;
		logic [CODE_W-1:0] trip_threshold;
		logic [CODE_W-1:0] time_code;
	} det_cfg_type;

	typedef struct packed {
		logic live_loss;
		logic loss_event;
		logic squelch;
	} det_stat_type;

endpackage

// ---- hw/rx_loss_detector.sv ----
// One receiver's loss detector with hysteresis and squelch delay timer.
// Assumes the amplitude code is synchronous to pclk, in 25 mV steps.
`timescale 1ns/1ps
`default_nettype none
module rx_loss_detector (
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire rx_loss_pkg::det_cfg_type     cfg,
	input  wire logic [rx_loss_pkg::CODE_W-1:0] amplitude,
	output rx_loss_pkg::det_stat_type         stat
);

	logic                             loss_reg;
	logic                             loss_next;
	logic                             event_reg;
	logic                             squelch_reg;
	logic [rx_loss_pkg::SQ_CNT_W-1:0] cnt_reg;
	logic [rx_loss_pkg::SQ_CNT_W-1:0] cnt_next;
	logic [rx_loss_pkg::SQ_CNT_W-1:0] target;

	// Between the two thresholds the state holds; that band is the hysteresis.
	assign loss_next = !cfg.enable ? 1'b0 :                                  // R12
		(amplitude < cfg.trip_threshold) ? 1'b1 :                        // R05
		(amplitude > cfg.release_threshold) ? 1'b0 :                     // R04
		loss_reg;

	assign target   = rx_loss_pkg::SQ_CYCLES[cfg.time_code];
	// Saturating compare keeps a shortened code from wrapping the count.
	assign cnt_next = !loss_reg ? '0 :
		(cnt_reg >= target) ? cnt_reg : cnt_reg + 1'b1;                  // R13

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loss_reg    <= 1'b0;
			event_reg   <= 1'b0;
			squelch_reg <= 1'b0;
			cnt_reg     <= '0;
		end else begin
			loss_reg    <= loss_next;
			event_reg   <= loss_next & ~loss_reg;
			squelch_reg <= loss_reg & (cnt_next >= target);                  // R13
			cnt_reg     <= cnt_next;
		end
	end

	assign stat.live_loss  = loss_reg;
	assign stat.loss_event = event_reg;
	assign stat.squelch    = squelch_reg;

endmodule
`default_nettype wire

// ---- tb/rx_loss_properties.sv ----
// Checker for the receiver signal-loss register block, bound to its top module.
// Assumes two-cycle APB transfers and shadows the enable, level and mask registers and the live spare bit from bus traffic.
`timescale 1ns/1ps
`default_nettype none
module rx_loss_properties (
	input wire logic                             pclk,
	input wire logic                             presetn,
	input wire logic                             psel,
	input wire logic                             penable,
	input wire logic                             pwrite,
	input wire logic [rx_loss_pkg::ADDR_W-1:0]   paddr,
	input wire logic [rx_loss_pkg::APB_DW-1:0]   pwdata,
	input wire logic [rx_loss_pkg::APB_DW-1:0]   prdata,
	input wire logic                             pslverr,
	input wire logic                             upper_group_irq,
	input wire logic                             loss_ref_enable,
	input wire logic                             loss_irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [7:0] level_sh;
	logic [7:0] mask_sh;
	logic [7:0] en_sh;
	logic       spare_sh;
	wire logic       wr_acc = psel && penable && pwrite && !pslverr;
	wire logic       rd_acc = psel && penable && !pwrite && !pslverr;
	wire logic [7:0] idx    = paddr[9:2];
	// Shadows let read data be judged without seeing the register bodies.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_sh <= 8'h62;
			mask_sh <= 8'h00;
			en_sh <= 8'h40;
			spare_sh <= 1'b0;
		end else if (wr_acc) begin
			case (idx)
				8'h88: en_sh <= pwdata[7:0];
				8'h8C: spare_sh <= pwdata[7];
				8'h8E: level_sh <= pwdata[7:0];
				8'h8F: mask_sh <= pwdata[7:0];
				default: ;
			endcase
		end
	end
	a_irq_follows_upper: assert property (upper_group_irq |=> loss_irq)
		else $error("interrupt low after upper group request");
	a_irq_masked_quiet: assert property (mask_sh[5:0] == 6'h00 && $past(mask_sh[5:0]) == 6'h00
		&& !$past(upper_group_irq) |-> !loss_irq) else $error("interrupt while all masked");
	a_status_bit6_zero: assert property (rd_acc && (idx == 8'h8C || idx == 8'h8D)
		|-> prdata[31:8] == 24'h000000 && !prdata[6]) else $error("status read bad bits");
	a_level_readback: assert property (rd_acc && idx == 8'h8E |-> prdata[7:0] == level_sh)
		else $error("threshold register read wrong");
	a_mask_readback: assert property (rd_acc && idx == 8'h8F |-> prdata[7:0] == mask_sh)
		else $error("mask register read wrong");
	a_ref_enable_follows: assert property (wr_acc && idx == 8'h88
		|=> loss_ref_enable == $past(pwdata[6])) else $error("reference enable not updated");
	a_spare_live_kept: assert property (rd_acc && idx == 8'h8C |-> prdata[7] == spare_sh)
		else $error("spare status bit lost");
	a_live_off_disabled: assert property (rd_acc && idx == 8'h8C && $past(en_sh[5:0], 2) == 6'h00
		&& $past(en_sh[5:0], 3) == 6'h00 |-> prdata[5:0] == 6'h00) else $error("live loss while off");
	cover property (rd_acc && idx == 8'h8C && prdata[5:0] != 6'h00);
	cover property (loss_irq && !upper_group_irq);
	cover property (psel && penable && pslverr);
endmodule
bind rx_signal_loss_status_irq rx_loss_properties i_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pslverr(pslverr), .upper_group_irq(upper_group_irq),
	.loss_ref_enable(loss_ref_enable), .loss_irq(loss_irq));
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the receiver signal-loss register block.
// Drives the APB and amplitude inputs itself; the checker is bound separately.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic            pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic            upper_group_irq, loss_ref_enable, loss_irq;
	logic [9:0]      paddr;
	logic [31:0]     pwdata, prdata, rd;
	logic [5:0][3:0] rx_amplitude;
	logic [5:0]      rx_squelch;
	int              fails = 0;
	int              comparisons = 0;
	rx_signal_loss_status_irq i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rx_amplitude(rx_amplitude),
		.upper_group_irq(upper_group_irq), .rx_squelch(rx_squelch),
		.loss_ref_enable(loss_ref_enable), .loss_irq(loss_irq));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic test_done;
		if (fails == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	// Holds the request until pready is seen high, then takes data at that edge.
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask
	task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk(rd, {24'h000000, exp});
	endtask
	// Outputs read at a rising edge are the settled values of the cycle before it.
	task automatic step(input logic [23:0] amps, input logic [7:0] exp);
		rx_amplitude <= amps;
		repeat (3) @(posedge pclk);
		rchk(8'h8C, exp);
	endtask
	initial begin
		repeat (5000) @(posedge pclk);
		fails++;
		test_done();
	end
	initial begin
		{presetn, psel, penable, pwrite, upper_group_irq} = 5'h00;
		paddr = 10'h000;
		pwdata = 32'h00000000;
		rx_amplitude = 24'h888888;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rchk(8'h88, 8'h40);
		chk(loss_ref_enable, 32'h1);
		rchk(8'h8C, 8'h00);
		rchk(8'h8D, 8'h00);
		rchk(8'h8E, 8'h62);
		rchk(8'h8F, 8'h00);
		wr(8'h8F, 8'hFF);
		rchk(8'h8F, 8'hFF);
		wr(8'h8C, 8'hFF);
		rchk(8'h8C, 8'h80);
		wr(8'h8D, 8'hBF);
		rchk(8'h8D, 8'h80);
		apb(1'b0, 8'h90, 8'h00);
		chk({err, rd[30:0]}, 32'h80000000);
		wr(8'h8F, 8'h00);
		wr(8'h88, 8'h7F);
		step(24'h170421, 8'hA9);
		step(24'h547644, 8'hA1);
		wr(8'h8E, 8'hC3);
		step(24'hDCDC32, 8'h81);
		rchk(8'h8D, 8'hA9);
		wr(8'h8D, 8'h01);
		rchk(8'h8D, 8'h28);
		chk(pready, 32'h1);
		chk(loss_irq, 32'h0);
		wr(8'h8F, 8'h02);
		repeat (2) @(posedge pclk);
		chk(loss_irq, 32'h0);
		wr(8'h8F, 8'hE0);
		repeat (2) @(posedge pclk);
		chk(loss_irq, 32'h1);
		wr(8'h8F, 8'h00);
		upper_group_irq <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(loss_irq, 32'h1);
		upper_group_irq <= 1'b0;
		wr(8'h88, 8'h00);
		rchk(8'h8C, 8'h80);
		chk(loss_ref_enable, 32'h0);
		rx_amplitude <= 24'hDDDDDD;
		wr(8'h89, 8'h90);
		wr(8'h88, 8'h03);
		chk(rx_squelch, 32'h0);
		rx_amplitude <= 24'hDDDD00;
		repeat (10) @(posedge pclk);
		chk(rx_squelch, 32'h1);
		repeat (50) @(posedge pclk);
		chk(rx_squelch, 32'h3);
		test_done();
	end
endmodule
`default_nettype wire
